// ===== core/roc_top.sv
// Behaviour
// R1: rising information switches the relay only after the on-delay (0..60000 ms) elapsed.
// R2: falling information switches the relay only after the holding time (0..9999 ms).
// R3: no-fault and contactor assignments force on-delay zero, other values ignored.
// R4: no-fault, brake, precharge, line assignments force holding time zero.
// R5: positive polarity drives relay 1 while conditioned information is true; default.
// R6: negative polarity drives relay 0 while information true, 1 otherwise.
// R7: no-fault, brake, precharge, line assignments lock polarity positive.
// R8: relays 3 and 4 share relay 2 choices, default none and zero times.
// R9: relay 3 exists only with option card one, relay 4 with card two.
// R10: reserved application assignments are configured only by their own functions.
// R11: information returning before a timer expires cancels it, relay unchanged.
`timescale 1ns/100ps
`default_nettype none
module roc_top
  import roc_pkg::*;
#(
  parameter int TICK_CYCLES_P = TICK_CYCLES
)
(
  // clock and reset
  input  wire logic                          i_clk,
  input  wire logic                          i_reset,
  input  wire logic                          i_ce,
  // option card presence pins
  input  wire logic                          i_option1_present,
  input  wire logic                          i_option2_present,
  // function conditions, one per assignment code
  input  wire logic [(1<<ASG_W)-1:0]         i_function_state,
  // settings write
  input  wire logic                          i_cfg_write,
  input  wire logic [1:0]                    i_cfg_relay,
  input  wire logic                          i_cfg_from_app,
  input  wire logic [ASG_W-1:0]              i_cfg_assign,
  input  wire logic [TIME_W-1:0]             i_cfg_on_delay,
  input  wire logic [HOLD_W-1:0]             i_cfg_hold,
  input  wire logic                          i_cfg_polarity,
  // settings readback
  output logic [RELAY_COUNT*ASG_W-1:0]       o_assign_rb,
  output logic [RELAY_COUNT*TIME_W-1:0]      o_on_delay_rb,
  output logic [RELAY_COUNT*HOLD_W-1:0]      o_hold_rb,
  output logic [RELAY_COUNT-1:0]             o_polarity_rb,
  output logic [RELAY_COUNT-1:0]             o_relay_present,
  output logic                               o_cfg_reject,
  // relay contacts, bit 0 is relay 2
  output logic [RELAY_COUNT-1:0]             o_relay
);

  localparam logic [16:0] TICK_LAST = 17'(TICK_CYCLES_P - 1);

  // ****************************************
  // millisecond timebase
  // ****************************************
  logic [16:0] tick_cnt_reg;
  logic [16:0] tick_cnt_next;
  logic        tick_reg;
  logic        tick_next;

  always_comb
  begin
    tick_next     = (tick_cnt_reg == TICK_LAST);
    tick_cnt_next = tick_next ? 17'h00000 : tick_cnt_reg + 17'h00001;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      tick_cnt_reg <= 17'h00000;
      tick_reg     <= 1'b0;
    end
    else if (i_ce)
    begin
      tick_cnt_reg <= tick_cnt_next;
      tick_reg     <= tick_next;
    end
  end

  // ****************************************
  // option card presence
  // ****************************************
  // a level only counts once the second and third stage agree
  logic [1:0] opt_s1_reg;
  logic [1:0] opt_s2_reg;
  logic [1:0] opt_s3_reg;
  logic [1:0] opt_reg;
  logic [1:0] opt_next;

  always_comb
  begin
    opt_next = (opt_s2_reg & opt_s3_reg) | (opt_reg & (opt_s2_reg ^ opt_s3_reg));
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      opt_s1_reg <= 2'h0;
      opt_s2_reg <= 2'h0;
      opt_s3_reg <= 2'h0;
      opt_reg    <= 2'h0;
    end
    else if (i_ce)
    begin
      opt_s1_reg <= {i_option2_present, i_option1_present};
      opt_s2_reg <= opt_s1_reg;
      opt_s3_reg <= opt_s2_reg;
      opt_reg    <= opt_next;
    end
  end

  logic [RELAY_COUNT-1:0] present;
  assign present = {opt_reg, 1'b1}; // [R9]

  // ****************************************
  // relay settings
  // ****************************************
  logic [ASG_W-1:0]  assign_reg [RELAY_COUNT];
  logic [ASG_W-1:0]  assign_next [RELAY_COUNT];
  logic [TIME_W-1:0] delay_reg [RELAY_COUNT];
  logic [TIME_W-1:0] delay_next [RELAY_COUNT];
  logic [HOLD_W-1:0] hold_reg [RELAY_COUNT];
  logic [HOLD_W-1:0] hold_next [RELAY_COUNT];
  logic              pol_reg [RELAY_COUNT];
  logic              pol_next [RELAY_COUNT];
  logic              reject_reg;
  logic              reject_next;

  // one write carries all four settings; a refused field keeps its old value unless the new assignment locks it to zero or positive
  always_comb
  begin
    reject_next = i_cfg_write && (i_cfg_relay >= 2'(RELAY_COUNT));
    for (int r = 0; r < RELAY_COUNT; r++)
    begin
      assign_next[r] = assign_reg[r];
      delay_next[r]  = delay_reg[r];
      hold_next[r]   = hold_reg[r];
      pol_next[r]    = pol_reg[r];
      if (!present[r])
      begin
        assign_next[r] = ASG_RESET; // [R8] [R9]
        delay_next[r]  = ON_DELAY_RESET;
        hold_next[r]   = HOLD_RESET;
        pol_next[r]    = POLARITY_RESET;
        if (i_cfg_write && i_cfg_relay == 2'(r))
          reject_next = 1'b1; // [R9]
      end
      else if (i_cfg_write && i_cfg_relay == 2'(r))
      begin
        if (roc_is_reserved(i_cfg_assign) && !i_cfg_from_app)
          reject_next = 1'b1; // [R10]
        else
          assign_next[r] = i_cfg_assign;
        if (i_cfg_on_delay > ON_DELAY_MAX_MS)
          reject_next = 1'b1;
        else if (roc_locks_delay(assign_next[r]) && i_cfg_on_delay != '0)
          reject_next = 1'b1; // [R3]
        else
          delay_next[r] = i_cfg_on_delay; // [R1]
        if (i_cfg_hold > HOLD_MAX_MS)
          reject_next = 1'b1;
        else if (roc_locks_hold(assign_next[r]) && i_cfg_hold != '0)
          reject_next = 1'b1; // [R4]
        else
          hold_next[r] = i_cfg_hold; // [R2]
        if (roc_locks_hold(assign_next[r]) && i_cfg_polarity != POLARITY_POSITIVE)
          reject_next = 1'b1; // [R7]
        else
          pol_next[r] = i_cfg_polarity; // [R5] [R6]
      end
      // the locks also hold when the assignment arrives from its own function
      if (roc_locks_delay(assign_next[r]))
        delay_next[r] = '0; // [R3]
      if (roc_locks_hold(assign_next[r]))
      begin
        hold_next[r] = '0; // [R4]
        pol_next[r]  = POLARITY_POSITIVE; // [R7]
      end
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      for (int r = 0; r < RELAY_COUNT; r++)
      begin
        assign_reg[r] <= ASG_RESET;
        delay_reg[r]  <= ON_DELAY_RESET;
        hold_reg[r]   <= HOLD_RESET;
        pol_reg[r]    <= POLARITY_RESET;
      end
      reject_reg <= 1'b0;
    end
    else if (i_ce)
    begin
      assign_reg <= assign_next;
      delay_reg  <= delay_next;
      hold_reg   <= hold_next;
      pol_reg    <= pol_next;
      reject_reg <= reject_next;
    end
  end

  assign o_cfg_reject    = reject_reg;
  assign o_relay_present = {opt_reg, 1'b1};

  // ****************************************
  // per relay conditioning
  // ****************************************
  for (genvar r = 0; r < RELAY_COUNT; r++)
  begin : g_relay
    logic info;
    assign info = (assign_reg[r] != ASG_NONE) && i_function_state[assign_reg[r]];

    roc_channel u_channel (
      .i_clk      (i_clk),
      .i_reset    (i_reset),
      .i_ce       (i_ce),
      .i_tick     (tick_reg),
      .i_enable   (present[r]),
      .i_info     (info),
      .i_on_delay (delay_reg[r]),
      .i_hold     ({2'h0, hold_reg[r]}),
      .i_polarity (pol_reg[r]),
      .o_relay    (o_relay[r]),
      .o_cond     ()
    );

    assign o_assign_rb[r*ASG_W +: ASG_W]     = assign_reg[r];
    assign o_on_delay_rb[r*TIME_W +: TIME_W] = delay_reg[r];
    assign o_hold_rb[r*HOLD_W +: HOLD_W]     = hold_reg[r];
    assign o_polarity_rb[r]                  = pol_reg[r];

    a_delay_locked: assert property (@(posedge i_clk) disable iff (i_reset) // [R3]
      roc_locks_delay(assign_reg[r]) |-> delay_reg[r] == '0)
      else $error("locked assignment carries a nonzero on-delay");

    a_hold_locked: assert property (@(posedge i_clk) disable iff (i_reset) // [R4]
      roc_locks_hold(assign_reg[r]) |-> hold_reg[r] == '0)
      else $error("locked assignment carries a nonzero holding time");

    a_polarity_locked: assert property (@(posedge i_clk) disable iff (i_reset) // [R7]
      roc_locks_hold(assign_reg[r]) |-> pol_reg[r] == POLARITY_POSITIVE)
      else $error("locked assignment is not positive polarity");

    a_absent_defaults: assert property (@(posedge i_clk) disable iff (i_reset) // [R9]
      i_ce && !present[r] |=> assign_reg[r] == ASG_NONE && delay_reg[r] == '0 && !o_relay[r])
      else $error("absent relay keeps settings or drives its contact");

    a_reserved_refused: assert property (@(posedge i_clk) disable iff (i_reset) // [R10]
      i_ce && i_cfg_write && i_cfg_relay == 2'(r) && !i_cfg_from_app && roc_is_reserved(i_cfg_assign)
        |=> o_cfg_reject && assign_reg[r] == $past(assign_reg[r]))
      else $error("operator write set a reserved assignment");

    a_reset_defaults: assert property (@(posedge i_clk) // [R8]
      i_reset |=> assign_reg[r] == ASG_NONE && hold_reg[r] == '0 && pol_reg[r] == POLARITY_POSITIVE)
      else $error("relay settings not at defaults after reset");
  end

  c_reject_seen: cover property (@(posedge i_clk) disable iff (i_reset) o_cfg_reject);
  c_card_inserted: cover property (@(posedge i_clk) disable iff (i_reset) $rose(opt_reg[0]));

endmodule : roc_top
`default_nettype wire

// ===== core/roc_pkg.sv
package roc_pkg;

  // ****************************************
  // timebase
  // ****************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_PERIOD_MS = 1;
  localparam int TICK_CYCLES = (TICK_PERIOD_MS * 1000000) / CLK_PERIOD_NS;

  // ****************************************
  // setting ranges and defaults
  // ****************************************
  localparam int RELAY_COUNT = 3;
  localparam int TIME_W = 16;
  localparam int HOLD_W = 14;
  localparam int ASG_W = 4;
  localparam logic [TIME_W-1:0] ON_DELAY_MAX_MS = 16'hEA60;
  localparam logic [HOLD_W-1:0] HOLD_MAX_MS = 14'h270F;
  localparam logic [TIME_W-1:0] ON_DELAY_RESET = 16'h0000;
  localparam logic [HOLD_W-1:0] HOLD_RESET = 14'h0000;
  localparam logic POLARITY_POSITIVE = 1'b1;
  localparam logic POLARITY_RESET = 1'b1;

  // ****************************************
  // assignment codes
  // ****************************************
  localparam logic [ASG_W-1:0] ASG_NONE = 4'h0;
  localparam logic [ASG_W-1:0] ASG_NO_FAULT = 4'h1;
  localparam logic [ASG_W-1:0] ASG_BRAKE_CONTACTOR_CTRL = 4'h8;
  localparam logic [ASG_W-1:0] ASG_LINE_CONTACTOR_CTRL = 4'h9;
  localparam logic [ASG_W-1:0] ASG_OUTPUT_CONTACTOR_CTRL = 4'hA;
  localparam logic [ASG_W-1:0] ASG_END_OF_REEL = 4'hB;
  localparam logic [ASG_W-1:0] ASG_COUNTER_WOBBLE_SYNC = 4'hC;
  localparam logic [ASG_W-1:0] ASG_DC_PRECHARGE_CTRL = 4'hD;
  localparam logic [ASG_W-1:0] ASG_RESET = 4'h0;

  typedef enum logic [1:0] {
    ST_OFF   = 2'b00,
    ST_DELAY = 2'b01,
    ST_ON    = 2'b10,
    ST_HOLD  = 2'b11
  } roc_state_type;

  function automatic logic roc_is_reserved(input logic [ASG_W-1:0] code);
    roc_is_reserved = (code >= ASG_BRAKE_CONTACTOR_CTRL) && (code <= ASG_DC_PRECHARGE_CTRL);
  endfunction : roc_is_reserved

  // hold time and polarity lock on the same set; output contactor is left out
  function automatic logic roc_locks_hold(input logic [ASG_W-1:0] code);
    roc_locks_hold = (code == ASG_NO_FAULT) || (code == ASG_BRAKE_CONTACTOR_CTRL)
                  || (code == ASG_DC_PRECHARGE_CTRL) || (code == ASG_LINE_CONTACTOR_CTRL);
  endfunction : roc_locks_hold

  function automatic logic roc_locks_delay(input logic [ASG_W-1:0] code);
    roc_locks_delay = roc_locks_hold(code) || (code == ASG_OUTPUT_CONTACTOR_CTRL);
  endfunction : roc_locks_delay

endpackage : roc_pkg

// ===== core/roc_channel.sv
`timescale 1ns/100ps
`default_nettype none
module roc_channel
  import roc_pkg::*;
(
  // clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_reset,
  input  wire logic              i_ce,
  // timebase and settings
  input  wire logic              i_tick,
  input  wire logic              i_enable,
  input  wire logic              i_info,
  input  wire logic [TIME_W-1:0] i_on_delay,
  input  wire logic [TIME_W-1:0] i_hold,
  input  wire logic              i_polarity,
  // relay
  output logic                   o_relay,
  output logic                   o_cond
);

  roc_state_type     state_reg;
  roc_state_type     state_next;
  logic [TIME_W-1:0] count_reg;
  logic [TIME_W-1:0] count_next;
  logic              cond_reg;
  logic              cond_next;
  logic              relay_reg;
  logic              relay_next;

  // ****************************************
  // delay and hold sequencing
  // ****************************************
  // the first tick may come at any point, so the wait runs one tick beyond the setting
  always_comb
  begin
    state_next = state_reg;
    count_next = count_reg;
    cond_next  = cond_reg;
    if (!i_enable)
    begin
      state_next = ST_OFF;
      count_next = '0;
      cond_next  = 1'b0;
    end
    else
    begin
      case (state_reg)
        ST_OFF:
          if (i_info)
          begin
            count_next = '0;
            if (i_on_delay == '0)
            begin
              state_next = ST_ON;
              cond_next  = 1'b1;
            end
            else
              state_next = ST_DELAY; // [R1]
          end
        ST_DELAY:
          if (!i_info)
            state_next = ST_OFF; // [R11]
          else if (i_tick)
          begin
            if (count_reg >= i_on_delay)
            begin
              state_next = ST_ON; // [R1]
              cond_next  = 1'b1;
            end
            else
              count_next = count_reg + 16'h0001;
          end
        ST_ON:
          if (!i_info)
          begin
            count_next = '0;
            if (i_hold == '0)
            begin
              state_next = ST_OFF;
              cond_next  = 1'b0;
            end
            else
              state_next = ST_HOLD; // [R2]
          end
        ST_HOLD:
          if (i_info)
            state_next = ST_ON; // [R11]
          else if (i_tick)
          begin
            if (count_reg >= i_hold)
            begin
              state_next = ST_OFF; // [R2]
              cond_next  = 1'b0;
            end
            else
              count_next = count_reg + 16'h0001;
          end
        default:
        begin
          state_next = ST_OFF;
          cond_next  = 1'b0;
        end
      endcase
    end
    relay_next = i_enable & (cond_next ~^ i_polarity); // [R5] [R6]
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      state_reg <= ST_OFF;
      count_reg <= '0;
      cond_reg  <= 1'b0;
      relay_reg <= 1'b0;
    end
    else if (i_ce)
    begin
      state_reg <= state_next;
      count_reg <= count_next;
      cond_reg  <= cond_next;
      relay_reg <= relay_next;
    end
  end

  assign o_relay = relay_reg;
  assign o_cond  = cond_reg;

  // ****************************************
  // checks
  // ****************************************
  a_on_delay_wait: assert property (@(posedge i_clk) disable iff (i_reset) // [R1]
    $rose(cond_reg) && ($past(i_on_delay) != '0) |->
      $past(state_reg) == ST_DELAY && $past(i_tick) && ($past(count_reg) >= $past(i_on_delay)))
    else $error("relay condition rose before the on-delay elapsed");

  a_hold_wait: assert property (@(posedge i_clk) disable iff (i_reset) // [R2]
    $fell(cond_reg) && $past(i_enable) && ($past(i_hold) != '0) |->
      $past(state_reg) == ST_HOLD && $past(i_tick) && ($past(count_reg) >= $past(i_hold)))
    else $error("relay condition fell before the holding time elapsed");

  a_positive_polarity: assert property (@(posedge i_clk) disable iff (i_reset) // [R5]
    $past(i_ce) && $past(i_enable) && $past(i_polarity) |-> o_relay == cond_reg)
    else $error("positive polarity relay does not follow the condition");

  a_negative_polarity: assert property (@(posedge i_clk) disable iff (i_reset) // [R6]
    $past(i_ce) && $past(i_enable) && !$past(i_polarity) |-> o_relay == !cond_reg)
    else $error("negative polarity relay is not inverted");

  a_cancel_delay: assert property (@(posedge i_clk) disable iff (i_reset) // [R11]
    i_ce && i_enable && state_reg == ST_DELAY && !i_info |=> state_reg == ST_OFF && !cond_reg)
    else $error("dropped information did not cancel the on-delay");

  c_delay_done: cover property (@(posedge i_clk) disable iff (i_reset)
    state_reg == ST_DELAY ##1 state_reg == ST_ON);
  c_hold_done: cover property (@(posedge i_clk) disable iff (i_reset)
    state_reg == ST_HOLD ##1 state_reg == ST_OFF);
  c_hold_cancel: cover property (@(posedge i_clk) disable iff (i_reset)
    state_reg == ST_HOLD ##1 state_reg == ST_ON);

endmodule : roc_channel
`default_nettype wire

// ===== dv/roc_contactor_model.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// contactor wired to one relay contact
// ****************************************
module roc_contactor_model
#(
  parameter int PICKUP_CYCLES = 3
)
(
  // clock
  input  wire logic i_clk,
  // coil and main contact
  input  wire logic i_coil,
  output logic      o_closed
);
  int count;

  initial o_closed = 1'b0;
  initial count = 0;

  // armature lags the coil; a dropped coil opens the contact by spring
  always @(posedge i_clk)
  begin
    if (i_coil === o_closed)
    begin
      count <= 0;
    end
    else if (count == PICKUP_CYCLES - 1)
    begin
      o_closed <= (i_coil === 1'b1);
      count    <= 0;
    end
    else
    begin
      count <= count + 1;
    end
  end
endmodule : roc_contactor_model
`default_nettype wire

// ===== dv/relay_output_conditioner_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module relay_output_conditioner_tb_top
  import roc_pkg::*;
;
  typedef struct {
    logic [1:0] rly; logic [3:0] asg; logic [15:0] dly; logic [13:0] hld; logic pol; logic app;
    logic [1:0] chk; logic [3:0] e_asg; logic [15:0] e_dly; logic [13:0] e_hld; logic e_pol; logic e_rej;
  } roc_row_type;

  logic                          clk;
  logic                          reset;
  logic                          ce;
  logic                          opt1;
  logic                          opt2;
  logic [(1<<ASG_W)-1:0]         fstate;
  logic                          cfg_write;
  logic [1:0]                    cfg_relay;
  logic                          cfg_from_app;
  logic [ASG_W-1:0]              cfg_assign;
  logic [TIME_W-1:0]             cfg_delay;
  logic [HOLD_W-1:0]             cfg_hold;
  logic                          cfg_pol;
  wire  [RELAY_COUNT*ASG_W-1:0]  assign_rb;
  wire  [RELAY_COUNT*TIME_W-1:0] delay_rb;
  wire  [RELAY_COUNT*HOLD_W-1:0] hold_rb;
  wire  [RELAY_COUNT-1:0]        pol_rb;
  wire  [RELAY_COUNT-1:0]        present;
  wire                           reject;
  wire  [RELAY_COUNT-1:0]        relay;
  wire  [RELAY_COUNT-1:0]        closed;
  int                            num_errors;
  int                            total_checks;
  int                            n;
  int                            r;
  logic                          seen;

  // rows: write fields, relay slice to read back, expected slice and reject
  roc_row_type rows [12] = '{
    '{2'h0, 4'h2, 16'h0005, 14'h0003, 1'b1, 1'b0, 2'h0, 4'h2, 16'h0005, 14'h0003, 1'b1, 1'b0},
    '{2'h0, 4'h1, 16'h0007, 14'h0004, 1'b0, 1'b0, 2'h0, 4'h1, 16'h0000, 14'h0000, 1'b1, 1'b1},
    '{2'h0, 4'hA, 16'h0007, 14'h0004, 1'b0, 1'b1, 2'h0, 4'hA, 16'h0000, 14'h0004, 1'b0, 1'b1},
    '{2'h0, 4'h8, 16'h0000, 14'h0000, 1'b1, 1'b0, 2'h0, 4'hA, 16'h0000, 14'h0000, 1'b1, 1'b1},
    '{2'h0, 4'h8, 16'h0000, 14'h0000, 1'b1, 1'b1, 2'h0, 4'h8, 16'h0000, 14'h0000, 1'b1, 1'b0},
    '{2'h0, 4'h9, 16'h0003, 14'h0002, 1'b0, 1'b1, 2'h0, 4'h9, 16'h0000, 14'h0000, 1'b1, 1'b1},
    '{2'h0, 4'hD, 16'h0000, 14'h0005, 1'b1, 1'b1, 2'h0, 4'hD, 16'h0000, 14'h0000, 1'b1, 1'b1},
    '{2'h0, 4'hB, 16'hEA60, 14'h270F, 1'b0, 1'b1, 2'h0, 4'hB, 16'hEA60, 14'h270F, 1'b0, 1'b0},
    '{2'h0, 4'hC, 16'hEA61, 14'h2710, 1'b1, 1'b1, 2'h0, 4'hC, 16'hEA60, 14'h270F, 1'b1, 1'b1},
    '{2'h1, 4'h3, 16'h0002, 14'h0001, 1'b0, 1'b0, 2'h1, 4'h3, 16'h0002, 14'h0001, 1'b0, 1'b0},
    '{2'h2, 4'h3, 16'h0001, 14'h0001, 1'b0, 1'b0, 2'h2, 4'h0, 16'h0000, 14'h0000, 1'b1, 1'b1},
    '{2'h3, 4'h2, 16'h0001, 14'h0001, 1'b0, 1'b0, 2'h0, 4'hC, 16'hEA60, 14'h270F, 1'b1, 1'b1}
  };

  roc_top #(.TICK_CYCLES_P(10)) u_dut (
    .i_clk(clk), .i_reset(reset), .i_ce(ce), .i_option1_present(opt1), .i_option2_present(opt2),
    .i_function_state(fstate), .i_cfg_write(cfg_write), .i_cfg_relay(cfg_relay),
    .i_cfg_from_app(cfg_from_app), .i_cfg_assign(cfg_assign), .i_cfg_on_delay(cfg_delay),
    .i_cfg_hold(cfg_hold), .i_cfg_polarity(cfg_pol), .o_assign_rb(assign_rb), .o_on_delay_rb(delay_rb),
    .o_hold_rb(hold_rb), .o_polarity_rb(pol_rb), .o_relay_present(present), .o_cfg_reject(reject),
    .o_relay(relay)
  );

  roc_contactor_model u_load [RELAY_COUNT-1:0] (.i_clk(clk), .i_coil(relay), .o_closed(closed));

  // ****************************************
  // helpers
  // ****************************************
  task automatic close_out();
    if (num_errors == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : close_out

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  // starts and ends just after a falling edge
  task automatic wr(input logic [1:0] rl, input logic [ASG_W-1:0] a, input logic [TIME_W-1:0] d,
                    input logic [HOLD_W-1:0] h, input logic p, input logic app);
    cfg_relay = rl;
    cfg_assign = a;
    cfg_delay = d;
    cfg_hold = h;
    cfg_pol = p;
    cfg_from_app = app;
    cfg_write = 1'b1;
    @(negedge clk);
    cfg_write = 1'b0;
  endtask : wr

  // counts rising edges until the relay reaches the level
  task automatic measure(input int idx, input logic lvl, output int cnt);
    cnt = 0;
    while (cnt < 200 && relay[idx] !== lvl)
    begin
      @(posedge clk);
      #1;
      cnt++;
    end
    @(negedge clk);
  endtask : measure

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial
  begin
    #100000;
    num_errors++;
    close_out();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    num_errors = 0;
    total_checks = 0;
    reset = 1'b1;
    ce = 1'b1;
    opt1 = 1'b1;
    opt2 = 1'b0;
    fstate = '0;
    cfg_write = 1'b0;
    cfg_relay = 2'h0;
    cfg_from_app = 1'b0;
    cfg_assign = 4'h0;
    cfg_delay = 16'h0000;
    cfg_hold = 14'h0000;
    cfg_pol = 1'b1;
    repeat (4) @(negedge clk);
    reset = 1'b0;
    repeat (6) @(negedge clk);
    chk(assign_rb, 0);
    chk(delay_rb, 0);
    chk(hold_rb, 0);
    chk(pol_rb, 3'h7);
    chk(relay, 3'h0);
    chk(present, 3'h3);
    foreach (rows[i])
    begin
      wr(rows[i].rly, rows[i].asg, rows[i].dly, rows[i].hld, rows[i].pol, rows[i].app);
      r = rows[i].chk;
      chk(reject, rows[i].e_rej);
      chk(assign_rb[r*ASG_W +: ASG_W], rows[i].e_asg);
      chk(delay_rb[r*TIME_W +: TIME_W], rows[i].e_dly);
      chk(hold_rb[r*HOLD_W +: HOLD_W], rows[i].e_hld);
      chk(pol_rb[r], rows[i].e_pol);
    end
    // the refusal flag is a single-cycle pulse
    @(negedge clk);
    chk(reject, 0);
    // timed switching on relay 2: 3 ms on-delay, 2 ms holding
    wr(2'h0, 4'h2, 16'h0003, 14'h0002, 1'b1, 1'b0);
    fstate[2] = 1'b1;
    measure(0, 1'b1, n);
    chk(n >= 30 && n <= 43, 1);
    repeat (4) @(negedge clk);
    chk(closed[0], 1);
    fstate[2] = 1'b0;
    measure(0, 1'b0, n);
    chk(n >= 20 && n <= 33, 1);
    // short pulses inside the timers must not reach the contact
    seen = 1'b0;
    fstate[2] = 1'b1;
    repeat (15) @(negedge clk) seen |= relay[0];
    fstate[2] = 1'b0;
    repeat (60) @(negedge clk) seen |= relay[0];
    chk(seen, 0);
    fstate[2] = 1'b1;
    measure(0, 1'b1, n);
    seen = 1'b1;
    fstate[2] = 1'b0;
    repeat (10) @(negedge clk) seen &= relay[0];
    fstate[2] = 1'b1;
    repeat (50) @(negedge clk) seen &= relay[0];
    chk(seen, 1);
    // zero times with negative polarity
    wr(2'h0, 4'h2, 16'h0000, 14'h0000, 1'b0, 1'b0);
    repeat (2) @(negedge clk);
    chk(relay[0], 0);
    fstate[2] = 1'b0;
    measure(0, 1'b1, n);
    chk(n, 1);
    // locked assignment switches at once
    wr(2'h0, 4'h1, 16'h0009, 14'h0009, 1'b1, 1'b0);
    // negative polarity left the idle contact closed; the forced positive polarity opens it
    @(negedge clk);
    chk(relay[0], 0);
    fstate[1] = 1'b1;
    measure(0, 1'b1, n);
    chk(n, 1);
    // second card arrives, first card is lost
    opt2 = 1'b1;
    repeat (6) @(negedge clk);
    chk(present, 3'h7);
    wr(2'h2, 4'h2, 16'h0000, 14'h0000, 1'b1, 1'b0);
    chk(reject, 0);
    fstate[2] = 1'b1;
    measure(2, 1'b1, n);
    chk(n, 1);
    opt1 = 1'b0;
    repeat (6) @(negedge clk);
    chk(present, 3'h5);
    chk(relay[1], 0);
    // reset in mid-run while relay 4 is closed
    reset = 1'b1;
    repeat (4) @(negedge clk);
    reset = 1'b0;
    @(negedge clk);
    chk(assign_rb, 0);
    chk(delay_rb, 0);
    chk(hold_rb, 0);
    chk(pol_rb, 3'h7);
    chk(relay, 3'h0);
    chk(present, 3'h1);
    repeat (6) @(negedge clk);
    chk(present, 3'h5);
    // a write while the clock enable is low is not taken
    ce = 1'b0;
    wr(2'h0, 4'h3, 16'h0004, 14'h0001, 1'b0, 1'b0);
    ce = 1'b1;
    @(negedge clk);
    chk(assign_rb[ASG_W-1:0], 4'h0);
    chk(pol_rb[0], 1);
    close_out();
  end
endmodule : relay_output_conditioner_tb_top
`default_nettype wire
